// ### core/ddr_init_pkg.sv
// constants for the ddr command-level device model
// assumes one command per rising edge of the link clock
package ddr_init_pkg;
	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam int BA_W = 2;
	localparam int MODE_W = 15;
	localparam int DQ_W = 16;
	localparam int BYTE_W = 8;
	// ---------------------------------------------------------------
	// operand fields
	// ---------------------------------------------------------------
	localparam int BL_LSB = 0;
	localparam int BL_W = 3;
	localparam int BT_BIT = 3;
	localparam int CL_LSB = 4;
	localparam int CL_W = 3;
	localparam int OP_LSB = 7;
	localparam int OP_W = 6;
	localparam int AP_BIT = 10;
	localparam int EMR_DLL_OFF_BIT = 0;
	localparam int EMR_HALF_DRIVE_BIT = 1;
	localparam logic [MODE_W-1:0] MODE_RESET = 15'h0000;
	localparam logic [ADDR_W-1:0] EXT_RESET = 13'h0000;
	// ---------------------------------------------------------------
	// encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] CL_CODE_2 = 3'h2;
	localparam logic [2:0] CL_CODE_3 = 3'h3;
	localparam logic [2:0] CL_CODE_1P5 = 3'h5;
	localparam logic [2:0] CL_CODE_2P5 = 3'h6;
	localparam logic [OP_W-1:0] OP_NORMAL = 6'h00;
	localparam logic [OP_W-1:0] OP_TEST = 6'h01;
	localparam logic [OP_W-1:0] OP_DLL_RESET = 6'h02;
	// {ras_n, cas_n, we_n} with cs_n low
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVATE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	// ---------------------------------------------------------------
	// timing in link clock cycles
	// ---------------------------------------------------------------
	localparam int DLL_LOCK_WAIT_CYCLES = 200;
	localparam int MRS_BUSY_CYCLES = 2;
	typedef enum logic [1:0] {
		DS_IDLE = 2'h0,
		DS_WAIT = 2'h1,
		DS_READ = 2'h3,
		DS_WRITE = 2'h2
	} data_state_t;
endpackage

// ### core/ddr_init_device.sv
// ddr sdram command decode, mode registers, burst engine, masked writes
// assumes ddr_ck is the controller's link clock, sys_clk at least 4x faster
`timescale 1ns/1ps
`default_nettype none
module ddr_init_device #(
	parameter int COL_W = 4
) (
	// system side
	input wire logic sys_clk,
	input wire logic resetn,
	// link command pins
	input wire logic ddr_ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ddr_init_pkg::BA_W-1:0] ba,
	input wire logic [ddr_init_pkg::ADDR_W-1:0] addr,
	// link data pins
	input wire logic [ddr_init_pkg::DQ_W-1:0] dq_in,
	output logic [ddr_init_pkg::DQ_W-1:0] dq_out,
	output logic dq_oe_n,
	input wire logic dqs_in,
	output logic dqs_out,
	output logic dqs_oe_n,
	input wire logic lower_byte_write_mask,
	input wire logic upper_byte_write_mask,
	// status in sys_clk domain
	output logic [ddr_init_pkg::MODE_W-1:0] operating_mode_setting,
	output logic [ddr_init_pkg::ADDR_W-1:0] ext_mode_setting,
	output logic dll_locked,
	output logic test_mode,
	output logic [3:0] banks_open
);
	localparam int MEM_W = ddr_init_pkg::BA_W + COL_W;
	localparam int STAT_W = ddr_init_pkg::MODE_W + ddr_init_pkg::ADDR_W + 6;

	if (COL_W < 3) begin : g_bad_col
		$error("COL_W must hold an eight-beat block");
	end

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic logic [3:0] bl_beats(input logic [2:0] code);
		case (code)
			ddr_init_pkg::BL_CODE_2: return 4'h2;
			ddr_init_pkg::BL_CODE_4: return 4'h4;
			ddr_init_pkg::BL_CODE_8: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction

	// half-clock latencies round up: data is whole-cycle aligned here
	function automatic logic [1:0] cl_cycles(input logic [2:0] code);
		case (code)
			ddr_init_pkg::CL_CODE_2: return 2'h2;
			ddr_init_pkg::CL_CODE_3: return 2'h3;
			ddr_init_pkg::CL_CODE_1P5: return 2'h2;
			ddr_init_pkg::CL_CODE_2P5: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] col,
			input logic [3:0] beat, input logic [3:0] beats, input logic inter);
		logic [COL_W-1:0] mask;
		logic [COL_W-1:0] off;
		mask = COL_W'(beats - 4'h1);
		off = inter ? (col ^ COL_W'(beat)) : COL_W'(col + COL_W'(beat));
		return (col & ~mask) | (off & mask);
	endfunction

	// ---------------------------------------------------------------
	// link reset release
	// ---------------------------------------------------------------
	logic [1:0] link_rst_ff;
	logic link_rstn;
	always_ff @(posedge ddr_ck or negedge resetn) begin
		if (!resetn) begin
			link_rst_ff <= 2'h0;
		end else begin
			link_rst_ff <= {link_rst_ff[0], 1'b1};
		end
	end
	assign link_rstn = link_rst_ff[1];

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	logic cke_prev_ff;
	logic [1:0] busy_ff;
	logic [ddr_init_pkg::MODE_W-1:0] mode_ff;
	logic [ddr_init_pkg::ADDR_W-1:0] ext_ff;
	logic [7:0] dll_cnt_ff;
	logic [3:0] bank_open_ff;
	ddr_init_pkg::data_state_t state_ff;
	logic cmd_ok;
	logic [2:0] cmd;
	logic mrs_take;
	logic rd_take;
	logic wr_take;
	logic [3:0] cur_beats;
	logic [1:0] cur_cl;
	logic [ddr_init_pkg::OP_W-1:0] cur_op;

	assign cmd = {ras_n, cas_n, we_n};
	// commands count only with cke high the edge before, outside the mrs gap
	assign cmd_ok = cke_prev_ff && !cs_n && (busy_ff == 2'h0);
	assign mrs_take = cmd_ok && (cmd == ddr_init_pkg::CMD_MRS);
	assign cur_beats = bl_beats(mode_ff[ddr_init_pkg::BL_LSB +: ddr_init_pkg::BL_W]);
	assign cur_cl = cl_cycles(mode_ff[ddr_init_pkg::CL_LSB +: ddr_init_pkg::CL_W]);
	assign cur_op = mode_ff[ddr_init_pkg::OP_LSB +: ddr_init_pkg::OP_W];
	// reserved burst codes leave any access unserved; reserved latency codes leave only a read unserved
	assign rd_take = cmd_ok && (cmd == ddr_init_pkg::CMD_READ) && (state_ff == ddr_init_pkg::DS_IDLE)
		&& (cur_beats != 4'h0) && (cur_cl != 2'h0);
	assign wr_take = cmd_ok && (cmd == ddr_init_pkg::CMD_WRITE) && (state_ff == ddr_init_pkg::DS_IDLE)
		&& (cur_beats != 4'h0);

	always_ff @(posedge ddr_ck or negedge link_rstn) begin
		if (!link_rstn) begin
			cke_prev_ff <= 1'b0;
			busy_ff <= 2'h0;
		end else begin
			cke_prev_ff <= cke;
			if (mrs_take) begin
				busy_ff <= 2'(ddr_init_pkg::MRS_BUSY_CYCLES - 1);
			end else if (busy_ff != 2'h0) begin
				busy_ff <= busy_ff - 2'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// mode registers and dll
	// ---------------------------------------------------------------
	always_ff @(posedge ddr_ck or negedge link_rstn) begin
		if (!link_rstn) begin
			mode_ff <= ddr_init_pkg::MODE_RESET;
			ext_ff <= ddr_init_pkg::EXT_RESET;
		end else if (mrs_take) begin
			if (!ba[0]) begin
				mode_ff <= {ba, addr};
			end else begin
				ext_ff <= addr;
			end
		end
	end

	always_ff @(posedge ddr_ck or negedge link_rstn) begin
		if (!link_rstn) begin
			dll_cnt_ff <= 8'(ddr_init_pkg::DLL_LOCK_WAIT_CYCLES);
		end else if (mrs_take && !ba[0] && (addr[ddr_init_pkg::OP_LSB +: ddr_init_pkg::OP_W]
				== ddr_init_pkg::OP_DLL_RESET)) begin
			dll_cnt_ff <= 8'(ddr_init_pkg::DLL_LOCK_WAIT_CYCLES);
		end else if (dll_cnt_ff != 8'h00) begin
			dll_cnt_ff <= dll_cnt_ff - 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// bank tracking
	// ---------------------------------------------------------------
	// auto-precharge closes the bank at once; spacing is the controller's job
	always_ff @(posedge ddr_ck or negedge link_rstn) begin
		if (!link_rstn) begin
			bank_open_ff <= 4'h0;
		end else if (cmd_ok) begin
			case (cmd)
				ddr_init_pkg::CMD_ACTIVATE: bank_open_ff[ba] <= 1'b1;
				ddr_init_pkg::CMD_PRECHARGE: begin
					if (addr[ddr_init_pkg::AP_BIT]) begin
						bank_open_ff <= 4'h0;
					end else begin
						bank_open_ff[ba] <= 1'b0;
					end
				end
				ddr_init_pkg::CMD_READ, ddr_init_pkg::CMD_WRITE: begin
					if (addr[ddr_init_pkg::AP_BIT]) begin
						bank_open_ff[ba] <= 1'b0;
					end
				end
				default: bank_open_ff <= bank_open_ff;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// burst engine
	// ---------------------------------------------------------------
	localparam int DQ_W_L = ddr_init_pkg::DQ_W;
	logic [DQ_W_L-1:0] mem [2**MEM_W];
	logic [1:0] lat_ff;
	logic [3:0] beat_ff;
	logic [3:0] beats_ff;
	logic [COL_W-1:0] col_ff;
	logic [ddr_init_pkg::BA_W-1:0] bank_ff;
	logic inter_ff;
	logic [MEM_W-1:0] beat_idx;

	assign beat_idx = {bank_ff, burst_col(col_ff, beat_ff, beats_ff, inter_ff)};

	always_ff @(posedge ddr_ck or negedge link_rstn) begin
		if (!link_rstn) begin
			state_ff <= ddr_init_pkg::DS_IDLE;
			lat_ff <= 2'h0;
			beat_ff <= 4'h0;
			beats_ff <= 4'h0;
			col_ff <= '0;
			bank_ff <= '0;
			inter_ff <= 1'b0;
			dq_out <= '0;
			dq_oe_n <= 1'b1;
			dqs_out <= 1'b0;
			dqs_oe_n <= 1'b1;
		end else begin
			case (state_ff)
				ddr_init_pkg::DS_IDLE: begin
					dq_oe_n <= 1'b1;
					dqs_oe_n <= 1'b1;
					dqs_out <= 1'b0;
					beat_ff <= 4'h0;
					beats_ff <= cur_beats;
					col_ff <= addr[COL_W-1:0];
					bank_ff <= ba;
					inter_ff <= mode_ff[ddr_init_pkg::BT_BIT];
					lat_ff <= cur_cl - 2'h1;
					if (rd_take) begin
						state_ff <= ddr_init_pkg::DS_WAIT;
					end else if (wr_take) begin
						state_ff <= ddr_init_pkg::DS_WRITE;
					end
				end
				ddr_init_pkg::DS_WAIT: begin
					if (lat_ff == 2'h1) begin
						state_ff <= ddr_init_pkg::DS_READ;
					end else begin
						lat_ff <= lat_ff - 2'h1;
					end
				end
				ddr_init_pkg::DS_READ: begin
					dq_out <= mem[beat_idx];
					dq_oe_n <= 1'b0;
					dqs_oe_n <= 1'b0;
					dqs_out <= ~dqs_out;
					beat_ff <= beat_ff + 4'h1;
					if (beat_ff == beats_ff - 4'h1) begin
						state_ff <= ddr_init_pkg::DS_IDLE;
					end
				end
				ddr_init_pkg::DS_WRITE: begin
					beat_ff <= beat_ff + 4'h1;
					if (beat_ff == beats_ff - 4'h1) begin
						state_ff <= ddr_init_pkg::DS_IDLE;
					end
				end
				default: state_ff <= ddr_init_pkg::DS_IDLE;
			endcase
		end
	end

	// storage has no reset; each byte lane obeys its own mask
	always_ff @(posedge ddr_ck) begin
		if (state_ff == ddr_init_pkg::DS_WRITE) begin
			if (!lower_byte_write_mask) begin
				mem[beat_idx][ddr_init_pkg::BYTE_W-1:0] <= dq_in[ddr_init_pkg::BYTE_W-1:0];
			end
			if (!upper_byte_write_mask) begin
				mem[beat_idx][DQ_W_L-1:ddr_init_pkg::BYTE_W] <= dq_in[DQ_W_L-1:ddr_init_pkg::BYTE_W];
			end
		end
	end

	// ---------------------------------------------------------------
	// status crossing
	// ---------------------------------------------------------------
	// toggle handshake; snapshot stays put far longer than the sync delay
	logic [STAT_W-1:0] stat_now;
	logic [STAT_W-1:0] stat_ff;
	logic stat_tgl_ff;
	logic [2:0] tgl_sync_ff;
	assign stat_now = {dll_cnt_ff == 8'h00 && !ext_ff[ddr_init_pkg::EMR_DLL_OFF_BIT],
		cur_op == ddr_init_pkg::OP_TEST, bank_open_ff, ext_ff, mode_ff};

	always_ff @(posedge ddr_ck or negedge link_rstn) begin
		if (!link_rstn) begin
			stat_ff <= '0;
			stat_tgl_ff <= 1'b0;
		end else if (stat_now != stat_ff) begin
			stat_ff <= stat_now;
			stat_tgl_ff <= ~stat_tgl_ff;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tgl_sync_ff <= 3'h0;
		end else begin
			tgl_sync_ff <= {tgl_sync_ff[1:0], stat_tgl_ff};
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			operating_mode_setting <= ddr_init_pkg::MODE_RESET;
			ext_mode_setting <= ddr_init_pkg::EXT_RESET;
			banks_open <= 4'h0;
			test_mode <= 1'b0;
			dll_locked <= 1'b0;
		end else if (tgl_sync_ff[2] != tgl_sync_ff[1]) begin
			{dll_locked, test_mode, banks_open, ext_mode_setting, operating_mode_setting} <= stat_ff;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_mode_load;
		@(posedge ddr_ck) disable iff (!link_rstn)
		mrs_take && !ba[0] |=> mode_ff == $past({ba, addr});
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode set not stored");

	property p_ext_load;
		@(posedge ddr_ck) disable iff (!link_rstn)
		mrs_take && ba[0] |=> ext_ff == $past(addr) && $stable(mode_ff);
	endproperty
	a_ext_load: assert property (p_ext_load) else $error("extended set wrong");

	property p_mrs_gap;
		@(posedge ddr_ck) disable iff (!link_rstn)
		mrs_take |=> !cmd_ok ##1 busy_ff == 2'h0;
	endproperty
	a_mrs_gap: assert property (p_mrs_gap) else $error("mode set gap wrong");

	property p_pre_all;
		@(posedge ddr_ck) disable iff (!link_rstn)
		cmd_ok && cmd == ddr_init_pkg::CMD_PRECHARGE && addr[ddr_init_pkg::AP_BIT] |=> bank_open_ff == 4'h0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

	property p_dll_wait;
		@(posedge ddr_ck) disable iff (!link_rstn)
		mrs_take && !ba[0] && addr[ddr_init_pkg::OP_LSB +: ddr_init_pkg::OP_W] == ddr_init_pkg::OP_DLL_RESET
		|=> dll_cnt_ff == 8'(ddr_init_pkg::DLL_LOCK_WAIT_CYCLES) ##1 dll_cnt_ff != 8'h00 [*8];
	endproperty
	a_dll_wait: assert property (p_dll_wait) else $error("dll lock wait cut short");

	property p_read_lat;
		@(posedge ddr_ck) disable iff (!link_rstn)
		rd_take && cur_cl == 2'h2 |=> dq_oe_n ##1 dq_oe_n ##1 !dq_oe_n && !dqs_oe_n;
	endproperty
	a_read_lat: assert property (p_read_lat) else $error("read data not at n plus latency");

	property p_idle_quiet;
		@(posedge ddr_ck) disable iff (!link_rstn)
		state_ff == ddr_init_pkg::DS_IDLE |=> dq_oe_n && dqs_oe_n;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("data driven outside read");

	property p_block;
		@(posedge ddr_ck) disable iff (!link_rstn)
		state_ff == ddr_init_pkg::DS_READ |-> (beat_idx[COL_W-1:0] & ~COL_W'(beats_ff - 4'h1))
			== (col_ff & ~COL_W'(beats_ff - 4'h1));
	endproperty
	a_block: assert property (p_block) else $error("burst left its block");

	property p_seq;
		@(posedge ddr_ck) disable iff (!link_rstn)
		state_ff == ddr_init_pkg::DS_READ && !inter_ff && beats_ff == 4'h4
		|-> beat_idx[1:0] == 2'(col_ff[1:0] + beat_ff[1:0]);
	endproperty
	a_seq: assert property (p_seq) else $error("sequential order wrong");

	property p_inter;
		@(posedge ddr_ck) disable iff (!link_rstn)
		state_ff == ddr_init_pkg::DS_READ && inter_ff && beats_ff == 4'h8
		|-> beat_idx[2:0] == (col_ff[2:0] ^ beat_ff[2:0]);
	endproperty
	a_inter: assert property (p_inter) else $error("interleaved order wrong");

	property p_mask;
		@(posedge ddr_ck) disable iff (!link_rstn)
		state_ff == ddr_init_pkg::DS_WRITE && lower_byte_write_mask && upper_byte_write_mask
		|=> mem[$past(beat_idx)] == $past(mem[beat_idx]);
	endproperty
	a_mask: assert property (p_mask) else $error("masked beat was stored");
endmodule // ddr_init_device
`default_nettype wire

// ### core/ddr_init_device_fix.sv
// holds no logic; the whole device sits in ddr_init_device.sv

// ### tb/ddr_ctrl_model.sv
// controller-side model: link clock, start-up sequence, command and burst tasks
// assumes the bench calls one task at a time and never overlaps bursts
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model #(
	parameter int TRP_CYC = 3,
	parameter int SETTLE_CYC = 1600
) (
	// link command pins
	output logic ddr_ck,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic [12:0] addr,
	// link data pins
	output logic [15:0] dq,
	output logic dqs,
	output logic lower_byte_write_mask,
	output logic upper_byte_write_mask
);
	// free running: the device wants a stable clock from power-up on
	initial begin
		ddr_ck = 1'b0;
		#37;
		forever #62.5 ddr_ck = ~ddr_ck;
	end
	initial begin
		cke = 1'b0;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = 2'h0;
		addr = 13'h0000;
		dq = 16'h0000;
		dqs = 1'b0;
		{upper_byte_write_mask, lower_byte_write_mask} = 2'h0;
	end
	// ---------------------------------------------------------------
	// command tasks, pins change at the falling edge
	// ---------------------------------------------------------------
	task automatic drive(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
		@(negedge ddr_ck);
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = c;
		ba = b;
		addr = a;
	endtask
	task automatic nop(input int n);
		repeat (n) drive(3'h7, 2'h0, 13'h0000);
	endtask
	task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
		drive(c, b, a);
		nop(1);
	endtask
	task automatic mode_set(input logic [1:0] b, input logic [12:0] a);
		cmd(ddr_init_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
		nop(TRP_CYC);
		cmd(ddr_init_pkg::CMD_MRS, b, a);
		nop(1);
	endtask
	task automatic settle();
		repeat (SETTLE_CYC) @(negedge ddr_ck);
	endtask
	task automatic init_start(input logic [12:0] emr, input logic [12:0] mr);
		nop(1);
		cke = 1'b1;
		nop(2);
		cmd(ddr_init_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
		nop(TRP_CYC);
		cmd(ddr_init_pkg::CMD_MRS, 2'h1, emr);
		nop(1);
		cmd(ddr_init_pkg::CMD_MRS, 2'h0, mr | 13'h0100);
		nop(1);
	endtask
	task automatic init_finish(input logic [12:0] mr);
		cmd(ddr_init_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
		nop(TRP_CYC);
		repeat (2) begin
			cmd(ddr_init_pkg::CMD_REFRESH, 2'h0, 13'h0000);
			nop(8);
		end
		cmd(ddr_init_pkg::CMD_MRS, 2'h0, mr);
		nop(200);
	endtask
	// no auto-precharge here, so reactivation spacing never arises
	task automatic write_burst(input logic [3:0] col, input int bl, input logic [15:0] d [8],
		input logic [1:0] mk [8]);
		drive(ddr_init_pkg::CMD_WRITE, 2'h0, {9'h000, col});
		for (int k = 0; k < bl; k++) begin
			nop(1);
			dq = d[k];
			{upper_byte_write_mask, lower_byte_write_mask} = mk[k];
			dqs = ~dqs;
		end
		nop(1);
		dq = ~dq;
		{upper_byte_write_mask, lower_byte_write_mask} = ~mk[bl - 1];
		dqs = 1'b0;
	endtask
endmodule // ddr_ctrl_model
`default_nettype wire

// ### tb/tb_top.sv
// bench for the ddr device: start-up, mode sets, bursts, masks, banks
// assumes ddr_ctrl_model drives the link side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk, resetn, ddr_ck, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_out, dqs_oe_n;
	logic lower_byte_write_mask, upper_byte_write_mask, dll_locked, test_mode;
	logic [1:0] ba;
	logic [12:0] addr, ext_mode_setting;
	logic [14:0] operating_mode_setting;
	logic [15:0] ctl_dq, dq_out, dq_wire;
	logic ctl_dqs, dqs_wire;
	logic [3:0] banks_open;
	logic [15:0] exp_mem [16];
	int n_mismatch = 0;
	int n_tests = 0;
	// the device owns the shared lines only while its enable is low
	assign dq_wire = (dq_oe_n === 1'b0) ? dq_out : ctl_dq;
	assign dqs_wire = (dqs_oe_n === 1'b0) ? dqs_out : ctl_dqs;
	ddr_ctrl_model ctl (.ddr_ck(ddr_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr), .dq(ctl_dq), .dqs(ctl_dqs), .lower_byte_write_mask(lower_byte_write_mask),
		.upper_byte_write_mask(upper_byte_write_mask));
	ddr_init_device #(.COL_W(4)) dut (.sys_clk(sys_clk), .resetn(resetn), .ddr_ck(ddr_ck), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_wire),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_in(dqs_wire), .dqs_out(dqs_out),
		.dqs_oe_n(dqs_oe_n), .lower_byte_write_mask(lower_byte_write_mask),
		.upper_byte_write_mask(upper_byte_write_mask), .operating_mode_setting(operating_mode_setting),
		.ext_mode_setting(ext_mode_setting), .dll_locked(dll_locked), .test_mode(test_mode),
		.banks_open(banks_open));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic [12:0] mw(input logic [5:0] op, input logic [2:0] cl, input logic bt,
		input logic [2:0] bl);
		return {op, cl, bt, bl};
	endfunction
	function automatic int bcol(input int st, input int k, input int bl, input logic il);
		int off;
		off = il ? ((st % bl) ^ k) : (((st % bl) + k) % bl);
		return st - (st % bl) + off;
	endfunction
	task automatic setup(input logic [2:0] cl, input logic bt, input logic [2:0] bl);
		ctl.mode_set(2'h0, mw(6'h00, cl, bt, bl));
		ctl.cmd(ddr_init_pkg::CMD_ACTIVATE, 2'h0, 13'h0000);
	endtask
	task automatic wr(input int st, input int bl, input logic il, input logic [15:0] d [8],
		input logic [1:0] mk [8]);
		int c;
		ctl.write_burst(4'(st), bl, d, mk);
		for (int k = 0; k < bl; k++) begin
			c = bcol(st, k, bl, il);
			if (!mk[k][0]) exp_mem[c][7:0] = d[k][7:0];
			if (!mk[k][1]) exp_mem[c][15:8] = d[k][15:8];
		end
	endtask
	task automatic rd(input int st, input int bl, input logic il, input int m);
		ctl.cmd(ddr_init_pkg::CMD_READ, 2'h0, {9'h000, 4'(st)});
		for (int j = 1; j <= m + bl; j++) begin
			@(negedge ddr_ck);
			check("read enable", {15'h0000, (j < m || j == m + bl)}, {15'h0000, dq_oe_n});
			check("strobe enable", {15'h0000, (j < m || j == m + bl)}, {15'h0000, dqs_oe_n});
			if (j >= m && j < m + bl) check("read strobe", 16'((j - m + 1) % 2), {15'h0000, dqs_out});
			if (j >= m && j < m + bl) check("read word", exp_mem[bcol(st, j - m, bl, il)], dq_out);
		end
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_power_up();
		logic [12:0] m = mw(6'h00, ddr_init_pkg::CL_CODE_2, 1'b0, ddr_init_pkg::BL_CODE_4);
		ctl.settle();
		check("dq released", 16'h0001, {15'h0000, dq_oe_n});
		check("dqs released", 16'h0001, {15'h0000, dqs_oe_n});
		ctl.init_start(13'h0002, m);
		ctl.nop(3);
		check("ext mode", 16'h0002, {3'h0, ext_mode_setting});
		check("early lock", 16'h0000, {15'h0000, dll_locked});
		ctl.init_finish(m);
		check("lock", 16'h0001, {15'h0000, dll_locked});
		check("mode", {3'h0, m}, {1'b0, operating_mode_setting});
		check("ext kept", 16'h0002, {3'h0, ext_mode_setting});
	endtask
	task automatic t_mode_hold();
		logic [12:0] a = mw(6'h00, ddr_init_pkg::CL_CODE_3, 1'b1, ddr_init_pkg::BL_CODE_8);
		ctl.mode_set(2'h0, mw(6'h01, ddr_init_pkg::CL_CODE_2P5, 1'b0, ddr_init_pkg::BL_CODE_2));
		ctl.nop(2);
		check("test mode on", 16'h0001, {15'h0000, test_mode});
		ctl.drive(ddr_init_pkg::CMD_MRS, 2'h0, a);
		ctl.drive(ddr_init_pkg::CMD_MRS, 2'h0, a ^ 13'h0077);
		ctl.nop(4);
		check("mode kept", {3'h0, a}, {1'b0, operating_mode_setting});
		check("test mode off", 16'h0000, {15'h0000, test_mode});
	endtask
	task automatic t_fill();
		logic [15:0] d [8];
		logic [1:0] mk [8];
		setup(ddr_init_pkg::CL_CODE_2, 1'b0, ddr_init_pkg::BL_CODE_8);
		for (int b = 0; b < 2; b++) begin
			for (int k = 0; k < 8; k++) begin
				d[k] = {4'(b + 1), 4'(k), 8'h3c ^ 8'(k)};
				mk[k] = 2'h0;
			end
			wr(b * 8 + 3, 8, 1'b0, d, mk);
		end
		check("dq released after write", 16'h0001, {15'h0000, dq_oe_n});
	endtask
	task automatic t_reads();
		logic [2:0] blc [6] = '{ddr_init_pkg::BL_CODE_4, ddr_init_pkg::BL_CODE_8, ddr_init_pkg::BL_CODE_2,
			ddr_init_pkg::BL_CODE_8, ddr_init_pkg::BL_CODE_4, ddr_init_pkg::BL_CODE_2};
		logic [2:0] clc [6] = '{ddr_init_pkg::CL_CODE_2, ddr_init_pkg::CL_CODE_3, ddr_init_pkg::CL_CODE_1P5,
			ddr_init_pkg::CL_CODE_2P5, ddr_init_pkg::CL_CODE_2, ddr_init_pkg::CL_CODE_3};
		int bl [6] = '{4, 8, 2, 8, 4, 2};
		int st [6] = '{1, 5, 11, 14, 7, 8};
		int m [6] = '{2, 3, 2, 3, 2, 3};
		logic il [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 6; i++) begin
			setup(clc[i], il[i], blc[i]);
			rd(st[i], bl[i], il[i], m[i]);
		end
		setup(ddr_init_pkg::CL_CODE_2, 1'b0, 3'h4);
		ctl.cmd(ddr_init_pkg::CMD_READ, 2'h0, 13'h0000);
		repeat (8) begin
			@(negedge ddr_ck);
			check("refused read", 16'h0001, {15'h0000, dq_oe_n});
		end
	endtask
	task automatic t_mask();
		logic [15:0] d [8] = '{16'ha1b2, 16'hc3d4, 16'he5f6, 16'h0718, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		logic [1:0] mk [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
		setup(ddr_init_pkg::CL_CODE_2, 1'b1, ddr_init_pkg::BL_CODE_4);
		wr(5, 4, 1'b1, d, mk);
		setup(ddr_init_pkg::CL_CODE_2, 1'b0, ddr_init_pkg::BL_CODE_4);
		rd(4, 4, 1'b0, 2);
	endtask
	task automatic t_banks();
		for (int b = 0; b < 4; b++) ctl.cmd(ddr_init_pkg::CMD_ACTIVATE, 2'(b), 13'h0000);
		ctl.nop(2);
		check("banks all open", 16'h000f, {12'h000, banks_open});
		ctl.cmd(ddr_init_pkg::CMD_PRECHARGE, 2'h2, 13'h0000);
		ctl.nop(2);
		check("one bank closed", 16'h000b, {12'h000, banks_open});
		ctl.cmd(ddr_init_pkg::CMD_PRECHARGE, 2'h1, 13'h0400);
		ctl.nop(2);
		check("all banks closed", 16'h0000, {12'h000, banks_open});
	endtask
	// ---------------------------------------------------------------
	// clock, watchdog, main sequence
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#800us;
		n_mismatch++;
		tally_and_finish();
	end
	// async reset; the link side still releases through its own two flops
	initial begin
		resetn = 1'b0;
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		t_power_up();
		t_mode_hold();
		t_fill();
		t_reads();
		t_mask();
		t_banks();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
